/* pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock, // System clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
	output logic [WIDTH-1:0] pin_out // Synchronised levels
);

	logic [WIDTH-1:0] first_reg;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("pin_sync WIDTH must be at least 1");
		end
	endgenerate

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			first_reg <= '0;
			pin_out <= '0;
		end else begin
			first_reg <= pin_in;
			pin_out <= first_reg;
		end
	end

endmodule
`default_nettype wire

/* press_fault_chk.sv */
// Assertion checker for the press fault manager
`timescale 1ns/1ps
`default_nettype none
module press_fault_chk #(
	parameter int FLASH_HALF_CYCLES = 4,
	parameter int TIME_WIDTH = 12
) (
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic selector_off, // Selector at OFF
	input wire logic zero_set, // Zero stored
	input wire logic [8:0] zero_angle, // Zero angle
	input wire logic stop_time_valid, // Time measured
	input wire logic [TIME_WIDTH-1:0] stop_time_ms, // Stop time
	input wire logic [TIME_WIDTH-1:0] stop_limit_ms, // Limit
	input wire logic [10:0] press_speed_spm, // Speed
	input wire logic press_stop, // Stop
	input wire logic fault_shown, // Fault
	input wire logic [7:0] fault_letter, // Letter
	input wire logic [3:0] fault_tens, // Tens
	input wire logic [3:0] fault_ones, // Ones
	input wire logic lockout_msg, // Lockout
	input wire logic brake_warning_led, // Lamp
	input wire logic [TIME_WIDTH-1:0] readout_time // Readout
);
	// Warning may wait out one dark flash phase
	localparam int WARN_WIN = 2 * FLASH_HALF_CYCLES + 4;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_stop; fault_shown || lockout_msg |-> press_stop; endproperty
	a_stop: assert property (p_stop) else $error("press not stopped");
	property p_digits; fault_shown |-> fault_tens <= 4'h9 && fault_ones <= 4'h9
		&& (fault_letter == 8'h45 || fault_letter == 8'h46 || fault_letter == 8'h48); endproperty
	a_digits: assert property (p_digits) else $error("bad fault code");
	property p_ehold; fault_letter == 8'h45 |=> fault_letter == 8'h45 && press_stop; endproperty
	a_ehold: assert property (p_ehold) else $error("class E fault lost");
	property p_lock; selector_off [*4] ##0 lockout_msg |=> lockout_msg; endproperty
	a_lock: assert property (p_lock) else $error("lockout dropped at OFF");
	property p_warn; stop_time_valid && stop_time_ms + 32'h0000000A >= stop_limit_ms
		|-> ##[1:WARN_WIN] brake_warning_led; endproperty
	a_warn: assert property (p_warn) else $error("no brake warning");
	property p_exceed; stop_time_valid && stop_time_ms > stop_limit_ms
		|=> press_stop && readout_time == $past(stop_time_ms); endproperty
	a_exceed: assert property (p_exceed) else $error("stop time not caught");
	property p_speed; press_speed_spm > 11'h3E8 && !fault_shown |=> fault_shown; endproperty
	a_speed: assert property (p_speed) else $error("overspeed missed");
	property p_zero; zero_set && zero_angle > 9'h01E && zero_angle < 9'h14A
		|=> {fault_letter, fault_tens, fault_ones} == {8'h45, 4'h0, 4'h7}; endproperty
	a_zero: assert property (p_zero) else $error("zero fault missed");
endmodule
bind press_fault_manager press_fault_chk #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES),
	.TIME_WIDTH(TIME_WIDTH)) chk (.*);
`default_nettype wire

/* press_fault_manager.sv */
// Fault supervision, latching and clearing for the press clutch/brake control
`timescale 1ns/1ps
`default_nettype none
`include "press_fault_map.svh"
module press_fault_manager
	import press_fault_pkg::*;
#(
	parameter int FLASH_HALF_CYCLES = `FLASH_HALF_CYCLES,
	parameter int TIME_WIDTH = 12
) (
	input wire logic clock, // 250 MHz system clock
	input wire logic reset_n, // Power-up reset, active low
	input wire logic clear_button, // Display clear button pin, high when pressed
	input wire logic remote_reset, // Remote reset switch pin, high when active
	input wire logic remote_reset_fitted, // Strap: remote reset switch installed
	input wire logic selector_off, // Stroke selector pin, high when at OFF
	input wire logic motor_on, // Main motor running pin
	input wire logic two_hand_inch, // Two-hand inch mode selected pin
	input wire logic estop_closed, // Emergency-stop circuit closed pin
	input wire logic prior_act_closed, // Pre-activation input closed pin
	input wire logic valve_relays_closed, // Dual safety valve output relays closed pin
	input wire logic dual_safety_valve_on, // Dual safety valve energised pin
	input wire logic resolver_wiring_ok, // Resolver wiring check pin
	input wire logic resolver_ok, // Resolver health pin
	input wire logic stroke_active, // Stroke initiated and in progress
	input wire logic [8:0] resolver_angle, // Crank angle in degrees
	input wire logic [10:0] press_speed_spm, // Measured press speed
	input wire logic zero_set, // Pulse: resolver zero position stored
	input wire logic [8:0] zero_angle, // Angle at which zero was stored
	input wire logic stop_time_valid, // Pulse: stopping time measured
	input wire logic [TIME_WIDTH-1:0] stop_time_ms, // Measured stopping time
	input wire logic [TIME_WIDTH-1:0] stop_limit_ms, // Configured stop-time limit
	input wire logic second_fault_req, // Pulse: second processor reports a fault
	input wire logic [6:0] second_fault_num, // Fault number from second processor
	input wire logic second_fault_lockout, // Reported fault is a lockout fault
	output logic press_stop, // Stop command to the press
	output logic fault_shown, // A fault code is on the display
	output logic [7:0] fault_letter, // Class letter as ASCII
	output logic [3:0] fault_tens, // Fault number tens digit
	output logic [3:0] fault_ones, // Fault number ones digit
	output logic lockout_msg, // Lockout message on the display
	output logic brake_warning_led, // Brake warning lamp drive
	output logic readout_flash, // Stopping time flashing on readout
	output logic [TIME_WIDTH-1:0] readout_time // Stopping time shown on readout
);

	generate
		if (FLASH_HALF_CYCLES < 1) begin : g_bad_flash
			$error("FLASH_HALF_CYCLES must be at least 1");
		end
		if (TIME_WIDTH < 5) begin : g_bad_time
			$error("TIME_WIDTH must hold the brake margin");
		end
	endgenerate

	function automatic logic [3:0] tens_of(input logic [6:0] num);
		logic [6:0] t;
		t = num / 7'h0A;
		return t[3:0];
	endfunction

	function automatic logic [3:0] ones_of(input logic [6:0] num);
		logic [6:0] o;
		o = num % 7'h0A;
		return o[3:0];
	endfunction

	function automatic logic [7:0] letter_of(input fault_class_t cls);
		case (cls)
			CLASS_E: return `CHAR_E;
			CLASS_F: return `CHAR_F;
			CLASS_H: return `CHAR_H;
			default: return `CHAR_BLANK;
		endcase
	endfunction

	logic [`SYNC_WIDTH-1:0] raw_pins;
	logic [`SYNC_WIDTH-1:0] pins;
	logic clear_prev_reg;
	logic remote_prev_reg;
	logic fitted_meta_reg;
	logic fitted_reg;
	logic clear_req;
	logic [8:0] angle_prev_reg;
	logic angle_seen_reg;

	assign raw_pins = {resolver_ok, resolver_wiring_ok, dual_safety_valve_on, valve_relays_closed,
		prior_act_closed, estop_closed, two_hand_inch, motor_on, selector_off, remote_reset,
		clear_button};

	pin_sync #(
		.WIDTH(`SYNC_WIDTH)
	) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.pin_in(raw_pins),
		.pin_out(pins)
	);

	// Strap for remote reset is a pin, so it passes two flip-flops as well
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fitted_meta_reg <= 1'b0;
			fitted_reg <= 1'b0;
		end else begin
			fitted_meta_reg <= remote_reset_fitted;
			fitted_reg <= fitted_meta_reg;
		end
	end

	// Pin detections wait until the synchroniser holds real pin levels
	logic [1:0] warm_reg;
	logic pins_ready;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			warm_reg <= 2'b00;
		end else begin
			warm_reg <= {warm_reg[0], 1'b1};
		end
	end

	assign pins_ready = warm_reg[1];

	// Edge detect on synchronised clear sources
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clear_prev_reg <= 1'b0;
			remote_prev_reg <= 1'b0;
		end else begin
			clear_prev_reg <= pins[`SYN_CLEAR];
			remote_prev_reg <= pins[`SYN_REMOTE];
		end
	end

	assign clear_req = (pins[`SYN_CLEAR] && !clear_prev_reg) ||
		(fitted_reg && pins[`SYN_REMOTE] && !remote_prev_reg);

	// Previous angle for motion detection
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			angle_prev_reg <= 9'h000;
			angle_seen_reg <= 1'b0;
		end else begin
			angle_prev_reg <= resolver_angle;
			angle_seen_reg <= 1'b1;
		end
	end

	// Detection, highest priority first
	logic det_valid;
	logic [6:0] det_num;
	fault_class_t det_class;
	logic det_lockout;
	logic zero_bad;
	logic drifted;

	assign zero_bad = zero_set && (zero_angle > `ZERO_HIGH_DEG) &&
		(zero_angle < `ZERO_LOW_DEG);
	assign drifted = pins_ready && angle_seen_reg && (resolver_angle != angle_prev_reg) &&
		!pins[`SYN_RELAYS] && !pins[`SYN_VALVE];

	always_comb begin
		det_valid = 1'b1;
		det_num = 7'h00;
		det_class = CLASS_F;
		det_lockout = 1'b0;
		if (zero_bad) begin
			det_num = `NUM_ZERO;
			det_class = CLASS_E;
		end else if (drifted) begin
			det_num = `NUM_DRIFT;
			det_lockout = 1'b1;
		end else if (pins_ready && stroke_active && !pins[`SYN_ESTOP]) begin
			det_num = `NUM_ESTOP;
		end else if (pins_ready && stroke_active && !pins[`SYN_PRIOR]) begin
			det_num = `NUM_PRIOR;
		end else if (press_speed_spm > `SPEED_LIMIT_SPM) begin
			det_num = `NUM_OVERSPEED;
		end else if (pins_ready && !pins[`SYN_WIRING]) begin
			det_num = `NUM_WIRING;
		end else if (pins_ready && !pins[`SYN_RESOLVER]) begin
			det_num = `NUM_RESOLVER;
		end else if (pins_ready && !pins[`SYN_MOTOR] && !pins[`SYN_INCH]) begin
			det_num = `NUM_MOTOR;
		end else if (second_fault_req) begin
			det_num = second_fault_num;
			det_class = CLASS_H;
			det_lockout = second_fault_lockout;
		end else begin
			det_valid = 1'b0;
		end
	end

	// Latched fault
	fault_class_t class_reg;
	logic [6:0] num_reg;
	logic lockout_pending_reg;
	logic clear_ok;
	logic take_new;

	assign clear_ok = clear_req && (class_reg == CLASS_F || class_reg == CLASS_H);
	// A new detection in the clearing cycle wins over the clear
	assign take_new = det_valid && (class_reg == CLASS_NONE || clear_ok ||
		(det_class == CLASS_E && class_reg != CLASS_E));

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			class_reg <= CLASS_NONE;
			num_reg <= 7'h00;
			lockout_pending_reg <= 1'b0;
		end else if (take_new) begin
			class_reg <= det_class;
			num_reg <= det_num;
			lockout_pending_reg <= det_lockout;
		end else if (clear_ok) begin
			class_reg <= CLASS_NONE;
			num_reg <= 7'h00;
			lockout_pending_reg <= 1'b0;
		end
	end

	// Display of the latched fault code
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fault_shown <= 1'b0;
			fault_letter <= `CHAR_BLANK;
			fault_tens <= 4'h0;
			fault_ones <= 4'h0;
		end else if (take_new) begin
			fault_shown <= 1'b1;
			fault_letter <= letter_of(det_class);
			fault_tens <= tens_of(det_num);
			fault_ones <= ones_of(det_num);
		end else if (clear_ok) begin
			fault_shown <= 1'b0;
			fault_letter <= `CHAR_BLANK;
			fault_tens <= 4'h0;
			fault_ones <= 4'h0;
		end
	end

	// Stop-time supervision
	logic stop_exceed_reg;
	logic brake_warn_reg;
	logic time_over;
	logic time_near;
	logic stop_clear;
	logic [TIME_WIDTH:0] time_plus_margin;

	assign time_over = stop_time_valid && (stop_time_ms > stop_limit_ms);
	assign time_plus_margin = {1'b0, stop_time_ms} + (TIME_WIDTH+1)'(`BRAKE_MARGIN_MS);
	assign time_near = stop_time_valid && (time_plus_margin >= {1'b0, stop_limit_ms});
	assign stop_clear = clear_req && stop_exceed_reg && !time_over;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stop_exceed_reg <= 1'b0;
			readout_time <= '0;
		end else if (time_over) begin
			stop_exceed_reg <= 1'b1;
			readout_time <= stop_time_ms;
		end else if (stop_clear) begin
			stop_exceed_reg <= 1'b0;
		end
	end

	// Warning is only removed by power-up reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			brake_warn_reg <= 1'b0;
		end else if (time_near) begin
			brake_warn_reg <= 1'b1;
		end
	end

	// Lockout message sequence
	lock_state_t lock_state_reg;
	logic lock_enter;

	assign lock_enter = (clear_ok && lockout_pending_reg) || stop_clear;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_state_reg <= LOCK_IDLE;
		end else if (lock_enter) begin
			lock_state_reg <= LOCK_WAIT_OFF;
		end else begin
			case (lock_state_reg)
				LOCK_IDLE: lock_state_reg <= LOCK_IDLE;
				LOCK_WAIT_OFF: begin
					if (pins[`SYN_SEL_OFF]) begin
						lock_state_reg <= LOCK_WAIT_SEL;
					end
				end
				LOCK_WAIT_SEL: begin
					if (!pins[`SYN_SEL_OFF]) begin
						lock_state_reg <= LOCK_IDLE;
					end
				end
				default: lock_state_reg <= LOCK_IDLE;
			endcase
		end
	end

	// Flash timing shared by brake lamp and readout
	logic [31:0] flash_cnt_reg;
	logic flash_phase_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			flash_cnt_reg <= 32'h0000_0000;
			flash_phase_reg <= 1'b0;
		end else if (flash_cnt_reg >= 32'(FLASH_HALF_CYCLES - 1)) begin
			flash_cnt_reg <= 32'h0000_0000;
			flash_phase_reg <= !flash_phase_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
		end
	end

	// Registered indications and the stop command
	logic stop_next;
	logic lock_next;

	assign lock_next = lock_enter || (lock_state_reg == LOCK_WAIT_OFF) ||
		(lock_state_reg == LOCK_WAIT_SEL && pins[`SYN_SEL_OFF]);
	assign stop_next = take_new || (class_reg != CLASS_NONE && !clear_ok) || time_over ||
		(stop_exceed_reg && !stop_clear) || lock_next;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			press_stop <= 1'b0;
			lockout_msg <= 1'b0;
			brake_warning_led <= 1'b0;
			readout_flash <= 1'b0;
		end else begin
			press_stop <= stop_next;
			lockout_msg <= lock_next;
			brake_warning_led <= brake_warn_reg && flash_phase_reg;
			readout_flash <= stop_exceed_reg && flash_phase_reg;
		end
	end

endmodule
`default_nettype wire

/* press_fault_manager_tb_top.sv */
// Testbench for the press fault manager
`timescale 1ns/1ps
`default_nettype none
module press_fault_manager_tb_top;
	logic clock = 1'b0, reset_n = 1'b0, clear_button = 1'b0, remote_reset = 1'b0;
	logic remote_reset_fitted = 1'b0, selector_off = 1'b0, two_hand_inch = 1'b0;
	logic stroke_active = 1'b0, zero_set = 1'b0, stop_time_valid = 1'b0, drift = 1'b0;
	logic second_fault_req = 1'b0, second_fault_lockout = 1'b0, seen;
	logic [5:0] brk = 6'h00;
	logic [8:0] zero_angle = 9'h000;
	logic [6:0] second_fault_num = 7'h00;
	logic [11:0] stop_time_ms = 12'h000, stop_limit_ms = 12'h064;
	logic motor_on, estop_closed, prior_act_closed, valve_relays_closed, dual_safety_valve_on;
	logic resolver_wiring_ok, resolver_ok, press_stop, fault_shown, lockout_msg;
	logic brake_warning_led, readout_flash;
	logic [8:0] resolver_angle;
	logic [10:0] press_speed_spm;
	logic [7:0] fault_letter;
	logic [3:0] fault_tens, fault_ones;
	logic [11:0] readout_time;
	int error_cnt = 0, total_checks = 0;
	wire [16:0] disp_code = {fault_shown, fault_letter, fault_tens, fault_ones};
	wire [2:0] loc_state = {lockout_msg, fault_shown, press_stop};
	localparam logic [16:0] NONE = {1'b0, 8'h20, 8'h00};
	localparam logic [7:0] TBL [6] = '{8'h10, 8'h13, 8'h14, 8'h04, 8'h05, 8'h03};
	localparam logic [8:0] ZA [3] = '{9'h14A, 9'h01E, 9'h01F};
	press_fault_manager #(.FLASH_HALF_CYCLES(4)) dut (.*);
	press_plant plant (.*);
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic tap(ref logic b);
		b = 1'b1;
		wt(2);
		b = 1'b0;
		wt(4);
	endtask
	// Collects the lamp or the readout flash over one and a half flash periods
	task automatic watch(input logic w);
		seen = 1'b0;
		repeat (12) begin
			@(negedge clock);
			seen = seen | (w ? readout_flash : brake_warning_led);
		end
	endtask
	task automatic meas(input logic [11:0] t);
		stop_time_ms = t;
		stop_time_valid = 1'b1;
		wt(1);
		stop_time_valid = 1'b0;
		wt(3);
	endtask
	task automatic sel_cycle;
		selector_off = 1'b1;
		wt(6);
		chk("loc off", 3'b101, loc_state);
		selector_off = 1'b0;
		wt(6);
		chk("loc done", 3'b000, loc_state);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		wt(4000);
		error_cnt++;
		conclude;
	end
	initial begin
		wt(20);
		reset_n = 1'b1;
		wt(3);
		stroke_active = 1'b1;
		for (int i = 0; i < 6; i++) begin
			brk = 6'h01 << i;
			wt(6);
			chk("pin", {1'b1, 8'h46, TBL[i]}, disp_code);
			brk = 6'h00;
			wt(6);
			chk("held", 1, press_stop & fault_shown);
			tap(clear_button);
			chk("clr", {NONE, press_stop}, {disp_code, 1'b0});
		end
		$display("pin test done");
		two_hand_inch = 1'b1;
		brk = 6'h01;
		wt(6);
		chk("inch", NONE, disp_code);
		brk = 6'h00;
		wt(3);
		two_hand_inch = 1'b0;
		wt(3);
		brk = 6'h01;
		wt(6);
		brk = 6'h00;
		for (int f = 0; f < 2; f++) begin
			remote_reset_fitted = f[0];
			tap(remote_reset);
			chk("remote", f[0] ? NONE : {1'b1, 8'h46, 8'h10}, disp_code);
		end
		$display("inch and remote test done");
		second_fault_num = 7'h26;
		second_fault_req = 1'b1;
		second_fault_lockout = 1'b1;
		wt(1);
		second_fault_req = 1'b0;
		second_fault_lockout = 1'b0;
		wt(2);
		chk("second", {1'b1, 8'h48, 8'h38}, disp_code);
		tap(clear_button);
		chk("second clr", NONE, disp_code);
		chk("second loc", 3'b101, loc_state);
		sel_cycle;
		drift = 1'b1;
		wt(6);
		drift = 1'b0;
		chk("drift", {1'b1, 8'h46, 8'h11}, disp_code);
		tap(clear_button);
		chk("loc", 3'b101, loc_state);
		sel_cycle;
		$display("second and drift test done");
		for (int k = 0; k < 3; k++) begin
			zero_angle = ZA[k];
			zero_set = 1'b1;
			wt(1);
			zero_set = 1'b0;
			wt(2);
			chk("zero", k == 2 ? {1'b1, 8'h45, 8'h07} : NONE, disp_code);
		end
		tap(clear_button);
		tap(remote_reset);
		chk("e held", {1'b1, 8'h45, 8'h07}, disp_code);
		reset_n = 1'b0;
		wt(2);
		reset_n = 1'b1;
		wt(3);
		chk("e power", NONE, disp_code);
		$display("zero test done");
		meas(12'h059);
		watch(1'b0);
		chk("warn low", 0, seen);
		meas(12'h05A);
		watch(1'b0);
		chk("warn", 1, seen);
		for (int j = 0; j < 2; j++) begin
			meas(12'h065 + j[11:0]);
			chk("time", 12'h065 + j[11:0], readout_time);
			chk("stop", 1, press_stop);
			watch(1'b1);
			chk("flash", 1, seen);
			tap(clear_button);
			chk("loc", 3'b101, loc_state);
		end
		sel_cycle;
		watch(1'b0);
		chk("warn kept", 1, seen);
		reset_n = 1'b0;
		wt(2);
		reset_n = 1'b1;
		watch(1'b0);
		chk("warn power", 0, seen);
		$display("stop time test done");
		conclude;
	end
endmodule
`default_nettype wire

/* press_fault_map.svh */
// Constants for the press fault manager
// Functional notes
// - Any detected problem stops the press and puts a fault on the display; the code shows a stop time over limit on the readout only, with no fault code.
// - Faults show as a class letter followed by a two-digit number.
// - Class E faults stay latched until power is cycled; clear is ignored.
// - Class F faults come from the main processor; clear button removes them.
// - Class H faults come from the second processor; cleared like class F.
// - A fitted remote reset clears F and H faults like the clear button.
// - Lockout faults show a lockout message until selector goes OFF then elsewhere.
// - Brake warning flashes when stopping time is within 10 ms of limit.
// - Brake warning stays on until power is cycled.
// - Stopping time over limit flashes that time and inhibits the press.
// - Running again with the condition persisting stops the next stroke again.
// - Stop-time fault clears by button, then lockout message and selector sequence.
// - Resolver fault when speed exceeds 1000 SPM or resolver/wiring fails.
// - Faulty resolver wiring raises F04; a defective resolver raises F05.
// - Zeroing outside 330 through top to 30 degrees raises E07.
// - Main motor switched off raises F10.
// - Motor-off fault is suppressed while two-hand inch mode is selected.
// - Resolver motion with valve relays open and valve off raises lockout F11.
// - E-stop pressed or circuit open after stroke start raises F13.
// - Pre-activation input opening after stroke start raises F14.
`ifndef PRESS_FAULT_MAP_SVH
`define PRESS_FAULT_MAP_SVH

`define CLOCK_KHZ 250000
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYCLES (`FLASH_HALF_MS * `CLOCK_KHZ)

`define NUM_OVERSPEED 7'h03
`define NUM_WIRING 7'h04
`define NUM_RESOLVER 7'h05
`define NUM_ZERO 7'h07
`define NUM_MOTOR 7'h0A
`define NUM_DRIFT 7'h0B
`define NUM_ESTOP 7'h0D
`define NUM_PRIOR 7'h0E

`define SPEED_LIMIT_SPM 11'h3E8
`define ZERO_LOW_DEG 9'h14A
`define ZERO_HIGH_DEG 9'h01E
`define BRAKE_MARGIN_MS 12'h00A

`define CHAR_E 8'h45
`define CHAR_F 8'h46
`define CHAR_H 8'h48
`define CHAR_BLANK 8'h20

`define SYNC_WIDTH 11
`define SYN_CLEAR 0
`define SYN_REMOTE 1
`define SYN_SEL_OFF 2
`define SYN_MOTOR 3
`define SYN_INCH 4
`define SYN_ESTOP 5
`define SYN_PRIOR 6
`define SYN_RELAYS 7
`define SYN_VALVE 8
`define SYN_WIRING 9
`define SYN_RESOLVER 10

`endif

/* press_fault_pkg.sv */
// Types shared by the press fault manager
package press_fault_pkg;

	typedef enum logic [1:0] {
		CLASS_NONE = 2'b00,
		CLASS_E = 2'b01,
		CLASS_F = 2'b10,
		CLASS_H = 2'b11
	} fault_class_t;

	typedef enum logic [1:0] {
		LOCK_IDLE = 2'b00,
		LOCK_WAIT_OFF = 2'b01,
		LOCK_WAIT_SEL = 2'b10
	} lock_state_t;

endpackage

/* press_plant.sv */
// Model of operator controls, resolver and press safety circuits
`timescale 1ns/1ps
`default_nettype none
module press_plant (
	input wire logic clock, // Clock
	input wire logic [5:0] brk, // Faults to inject
	input wire logic drift, // Ram creeps, valve off
	output logic motor_on, // Motor
	output logic estop_closed, // E-stop
	output logic prior_act_closed, // Pre-activation
	output logic valve_relays_closed, // Relays
	output logic dual_safety_valve_on, // Valve
	output logic resolver_wiring_ok, // Wiring
	output logic resolver_ok, // Resolver
	output logic [8:0] resolver_angle, // Angle
	output logic [10:0] press_speed_spm // Speed
);
	initial begin
		{resolver_ok, resolver_wiring_ok, prior_act_closed, estop_closed, motor_on} = 5'h1F;
		{valve_relays_closed, dual_safety_valve_on} = 2'h3;
		resolver_angle = 9'h000;
		press_speed_spm = 11'h3E8;
	end
	// Changes just after the rising edge, as the real circuits would
	always @(posedge clock) begin
		{resolver_ok, resolver_wiring_ok, prior_act_closed, estop_closed, motor_on} <= ~brk[4:0];
		valve_relays_closed <= !drift;
		dual_safety_valve_on <= !drift;
		press_speed_spm <= brk[5] ? 11'h3E9 : 11'h3E8;
		if (drift)
			resolver_angle <= (resolver_angle == 9'h167) ? 9'h000 : resolver_angle + 9'h001;
	end
endmodule
`default_nettype wire
